// File: rtl/agu_consts.svh
// Purpose: Constants of the address generation and bus cycle block
// Assumes: Included by the block and its package users
// Notes: Widths, fills, steps and the default peripheral map only, no logic
`ifndef AGU_CONSTS_SVH
`define AGU_CONSTS_SVH

// ----------------------------------------
// Address widths
// ----------------------------------------
`define AGU_EA_W 24
`define AGU_BUS_AW 16

// ----------------------------------------
// Fills and steps
// ----------------------------------------
`define AGU_ABS8_FILL 16'hFFFF
`define AGU_MIND_FILL 16'h0000
`define AGU_EXT24_TOP 8'h00
`define AGU_STEP_BYTE 32'h0000_0001
`define AGU_STEP_WORD 32'h0000_0002
`define AGU_STEP_LONG 32'h0000_0004

// ----------------------------------------
// Default peripheral map
// ----------------------------------------
`define AGU_PERIPH_BASE 16'hF000
`define AGU_PERIPH_END 16'hFEFF
`define AGU_PERIPH_WIDE_END 16'hF7FF
`define AGU_PERIPH_SLOW_BASE 16'hFC00

`endif

// File: rtl/agu_pkg.sv
// Purpose: Types of the address generation and bus cycle block
// Assumes: Nothing imported by users
// Notes: Request and bus carriers are packed structs
package agu_pkg;

	typedef enum logic [3:0] {
		AGU_M_REG = 4'h0,
		AGU_M_IND = 4'h1,
		AGU_M_DISP = 4'h2,
		AGU_M_POSTINC = 4'h3,
		AGU_M_PREDEC = 4'h4,
		AGU_M_ABS = 4'h5,
		AGU_M_IMM = 4'h6,
		AGU_M_PCREL = 4'h7,
		AGU_M_MIND = 4'h8
	} agu_mode_t;

	typedef enum logic [1:0] {
		AGU_SZ_BYTE = 2'h0,
		AGU_SZ_WORD = 2'h1,
		AGU_SZ_LONG = 2'h2
	} agu_size_t;

	typedef enum logic [1:0] {
		AGU_C_ARITH = 2'h0,
		AGU_C_XFER = 2'h1,
		AGU_C_BIT = 2'h2,
		AGU_C_BRANCH = 2'h3
	} agu_cls_t;

	typedef enum logic [2:0] {
		AGU_B_SET = 3'h0,
		AGU_B_CLR = 3'h1,
		AGU_B_NOT = 3'h2,
		AGU_B_TST = 3'h3,
		AGU_B_OTHER = 3'h4
	} agu_bitop_t;

	typedef enum logic [1:0] {
		AGU_CPU_RESET = 2'h0,
		AGU_CPU_EXEC = 2'h1,
		AGU_CPU_HALT = 2'h2,
		AGU_CPU_EXC = 2'h3
	} agu_cpu_t;

	typedef enum logic [1:0] {
		AGU_T_IDLE = 2'h0,
		AGU_T_1 = 2'h1,
		AGU_T_2 = 2'h2,
		AGU_T_3 = 2'h3
	} agu_bus_st_t;

	// Extension length: 0 = 8 bits, 1 = 16 bits, 2 = 24 bits, 3 = 32 bits
	typedef struct packed {
		agu_cls_t cls;
		agu_mode_t mode;
		agu_size_t size;
		logic [3:0] reg_sel;
		logic [1:0] ext_len;
		logic [31:0] ext;
		logic [23:0] pc;
		logic write;
		logic [31:0] wdata;
		logic bit_from_reg;
		logic [2:0] bit_reg;
		agu_bitop_t bitop;
		logic trap;
	} agu_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic byte_sz;
		logic [15:0] wdata;
	} agu_bus_t;

endpackage

// File: rtl/agu_core.sv
// Purpose: Effective address generation and on-chip bus cycles
// Assumes: Requests come from the decoder on clk_in; bus partner answers in the last state
// Notes: Sub clock selection happens upstream; one state is one clk_in period
`timescale 1ns/1ps
`include "agu_consts.svh"

module agu_core #(
	parameter logic [15:0] PERIPH_BASE = `AGU_PERIPH_BASE,
	parameter logic [15:0] PERIPH_END = `AGU_PERIPH_END,
	parameter logic [15:0] PERIPH_WIDE_END = `AGU_PERIPH_WIDE_END,
	parameter logic [15:0] PERIPH_SLOW_BASE = `AGU_PERIPH_SLOW_BASE
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Request
	input wire logic req_valid_in,
	input wire agu_pkg::agu_req_t req_in,
	// Register load port
	input wire logic rf_we_in,
	input wire logic [2:0] rf_idx_in,
	input wire logic [31:0] rf_data_in,
	// Processor state events
	input wire logic sleep_in,
	input wire logic wake_in,
	input wire logic exc_in,
	input wire logic exc_done_in,
	// On-chip bus
	input wire logic [15:0] bus_rdata_in,
	output agu_pkg::agu_bus_t bus_out,
	// Answer
	output logic ready_out,
	output logic done_out,
	output logic err_out,
	output logic [31:0] result_out,
	output logic [23:0] target_out,
	output logic [2:0] bitnum_out,
	output logic [1:0] trap_sel_out,
	output agu_pkg::agu_cpu_t cpu_state_out
);

	initial begin
		if (PERIPH_BASE > PERIPH_END || PERIPH_WIDE_END < PERIPH_BASE ||
			PERIPH_SLOW_BASE < PERIPH_BASE)
			$error("agu_core: peripheral map out of order");
	end

	typedef struct packed {
		agu_pkg::agu_cpu_t cpu;
		agu_pkg::agu_bus_st_t bst;
		logic [7:0][31:0] rf;
		agu_pkg::agu_bus_t bus;
		logic slow;
		logic bb;
		logic [2:0] nbeats;
		logic [1:0] beat;
		logic [31:0] data;
		logic [31:0] wl;
		logic mind;
		logic postinc;
		logic [2:0] wb_idx;
		logic [31:0] wb_val;
		logic ready;
		logic done;
		logic err;
		logic [31:0] result;
		logic [23:0] target;
		logic [2:0] bitnum;
		logic [1:0] trap_sel;
	} agu_state_t;

	agu_state_t s_r;
	agu_state_t s_nxt;

	function automatic logic [31:0] size_step(input agu_pkg::agu_size_t sz);
		unique case (sz)
			agu_pkg::AGU_SZ_BYTE: size_step = `AGU_STEP_BYTE;
			agu_pkg::AGU_SZ_WORD: size_step = `AGU_STEP_WORD;
			default: size_step = `AGU_STEP_LONG;
		endcase
	endfunction

	// ----------------------------------------
	// Address formation
	// ----------------------------------------
	logic acc;
	logic [31:0] regv;
	logic [31:0] disp32;
	logic [31:0] step;
	logic [31:0] dec32;
	logic [31:0] sum32;
	logic [23:0] ea24;
	logic [23:0] pcrel24;
	logic [15:0] ea16;
	logic legal;
	logic no_bus;
	logic periph;
	logic wide;
	logic bad_width;

	assign acc = req_valid_in && s_r.ready;
	assign regv = s_r.rf[req_in.reg_sel[2:0]];
	assign step = size_step(req_in.size);
	// A 24-bit extension arrives with a zero top byte
	assign disp32 = (req_in.ext_len == 2'h1) ? {{16{req_in.ext[15]}}, req_in.ext[15:0]} :
		{`AGU_EXT24_TOP, req_in.ext[23:0]};
	assign sum32 = regv + disp32;
	assign dec32 = regv - step;
	assign pcrel24 = req_in.pc + ((req_in.ext_len == 2'h0) ?
		{{16{req_in.ext[7]}}, req_in.ext[7:0]} :
		{{8{req_in.ext[15]}}, req_in.ext[15:0]});

	always_comb begin
		unique case (req_in.mode)
			agu_pkg::AGU_M_IND: ea24 = regv[23:0];
			agu_pkg::AGU_M_POSTINC: ea24 = regv[23:0];
			agu_pkg::AGU_M_DISP: ea24 = sum32[23:0];
			agu_pkg::AGU_M_PREDEC: ea24 = dec32[23:0];
			agu_pkg::AGU_M_ABS: begin
				if (req_in.ext_len == 2'h0)
					ea24 = {`AGU_ABS8_FILL, req_in.ext[7:0]};
				else if (req_in.ext_len == 2'h1)
					ea24 = {{8{req_in.ext[15]}}, req_in.ext[15:0]};
				else
					ea24 = req_in.ext[23:0];
			end
			agu_pkg::AGU_M_PCREL: ea24 = pcrel24;
			agu_pkg::AGU_M_MIND: ea24 = {`AGU_MIND_FILL, req_in.ext[7:0]};
			default: ea24 = 24'h00_0000;
		endcase
	end

	// Upper eight bits never reach the bus
	assign ea16 = ea24[15:0];
	assign periph = ea16 >= PERIPH_BASE && ea16 <= PERIPH_END;
	assign wide = !periph || ea16 <= PERIPH_WIDE_END;
	assign bad_width = periph && wide && req_in.size != agu_pkg::AGU_SZ_WORD;

	always_comb begin
		unique case (req_in.cls)
			agu_pkg::AGU_C_ARITH: legal = req_in.mode == agu_pkg::AGU_M_REG ||
				req_in.mode == agu_pkg::AGU_M_IMM;
			agu_pkg::AGU_C_XFER: legal = req_in.mode != agu_pkg::AGU_M_PCREL &&
				req_in.mode != agu_pkg::AGU_M_MIND;
			agu_pkg::AGU_C_BIT: legal = (req_in.mode == agu_pkg::AGU_M_REG ||
				req_in.mode == agu_pkg::AGU_M_IND || req_in.mode == agu_pkg::AGU_M_ABS) &&
				!(req_in.bit_from_reg && req_in.bitop == agu_pkg::AGU_B_OTHER);
			default: legal = req_in.mode == agu_pkg::AGU_M_IND ||
				req_in.mode == agu_pkg::AGU_M_ABS || req_in.mode == agu_pkg::AGU_M_PCREL ||
				req_in.mode == agu_pkg::AGU_M_MIND;
		endcase
	end

	// Jumps through register or absolute and PC relative calls need no operand fetch
	assign no_bus = req_in.mode == agu_pkg::AGU_M_REG || req_in.mode == agu_pkg::AGU_M_IMM ||
		(req_in.cls == agu_pkg::AGU_C_BRANCH && req_in.mode != agu_pkg::AGU_M_MIND);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic [31:0] shifted;
	logic [31:0] wl_start;

	assign shifted = s_r.bb ? {s_r.data[23:0], bus_rdata_in[7:0]} :
		{s_r.data[15:0], bus_rdata_in};

	always_comb begin
		unique case (req_in.size)
			agu_pkg::AGU_SZ_BYTE: wl_start = {req_in.wdata[7:0], 24'h00_0000};
			agu_pkg::AGU_SZ_WORD: wl_start = {req_in.wdata[15:0], 16'h0000};
			default: wl_start = req_in.wdata;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.err = 1'b0;
		unique case (s_r.cpu)
			agu_pkg::AGU_CPU_RESET: s_nxt.cpu = agu_pkg::AGU_CPU_EXEC;
			agu_pkg::AGU_CPU_EXEC: begin
				if (exc_in)
					s_nxt.cpu = agu_pkg::AGU_CPU_EXC;
				else if (sleep_in && s_r.bst == agu_pkg::AGU_T_IDLE && !acc)
					s_nxt.cpu = agu_pkg::AGU_CPU_HALT;
			end
			agu_pkg::AGU_CPU_HALT: begin
				if (exc_in)
					s_nxt.cpu = agu_pkg::AGU_CPU_EXC;
				else if (wake_in)
					s_nxt.cpu = agu_pkg::AGU_CPU_EXEC;
			end
			agu_pkg::AGU_CPU_EXC: begin
				if (exc_done_in)
					s_nxt.cpu = agu_pkg::AGU_CPU_EXEC;
			end
		endcase
		if (rf_we_in)
			s_nxt.rf[rf_idx_in] = rf_data_in;
		unique case (s_r.bst)
			agu_pkg::AGU_T_IDLE: begin
				if (acc) begin
					s_nxt.bitnum = req_in.bit_from_reg ? s_r.rf[req_in.bit_reg][2:0] :
						req_in.ext[2:0];
					s_nxt.trap_sel = req_in.trap ? req_in.ext[1:0] : 2'h0;
					s_nxt.target = ea24;
					if (!legal || (!no_bus && bad_width)) begin
						s_nxt.done = 1'b1;
						s_nxt.err = 1'b1;
					end else if (no_bus) begin
						s_nxt.done = 1'b1;
						if (req_in.mode == agu_pkg::AGU_M_IMM) begin
							unique case (req_in.size)
								agu_pkg::AGU_SZ_BYTE: s_nxt.result = {24'h00_0000, req_in.ext[7:0]};
								agu_pkg::AGU_SZ_WORD: s_nxt.result = {16'h0000, req_in.ext[15:0]};
								default: s_nxt.result = req_in.ext;
							endcase
						end else begin
							unique case (req_in.size)
								agu_pkg::AGU_SZ_BYTE: s_nxt.result = {24'h00_0000,
									req_in.reg_sel[3] ? regv[7:0] : regv[15:8]};
								agu_pkg::AGU_SZ_WORD: s_nxt.result = {16'h0000,
									req_in.reg_sel[3] ? regv[31:16] : regv[15:0]};
								default: s_nxt.result = regv;
							endcase
						end
					end else begin
						s_nxt.bst = agu_pkg::AGU_T_1;
						s_nxt.bus.addr = ea16;
						s_nxt.bus.rd = !req_in.write;
						s_nxt.bus.wr = req_in.write;
						s_nxt.bb = !wide || req_in.size == agu_pkg::AGU_SZ_BYTE;
						s_nxt.bus.byte_sz = s_nxt.bb;
						s_nxt.slow = periph && ea16 >= PERIPH_SLOW_BASE;
						if (!wide)
							s_nxt.nbeats = 3'(step);
						else
							s_nxt.nbeats = (req_in.size == agu_pkg::AGU_SZ_LONG) ? 3'h2 : 3'h1;
						s_nxt.beat = 2'h0;
						s_nxt.data = 32'h0000_0000;
						s_nxt.wl = wl_start;
						s_nxt.bus.wdata = s_nxt.bb ? {wl_start[31:24], wl_start[31:24]} :
							wl_start[31:16];
						s_nxt.mind = req_in.mode == agu_pkg::AGU_M_MIND;
						s_nxt.postinc = req_in.mode == agu_pkg::AGU_M_POSTINC;
						s_nxt.wb_idx = req_in.reg_sel[2:0];
						s_nxt.wb_val = regv + step;
						if (req_in.mode == agu_pkg::AGU_M_PREDEC)
							s_nxt.rf[req_in.reg_sel[2:0]] = dec32;
					end
				end
			end
			agu_pkg::AGU_T_1: s_nxt.bst = agu_pkg::AGU_T_2;
			agu_pkg::AGU_T_2, agu_pkg::AGU_T_3: begin
				if (s_r.bst == agu_pkg::AGU_T_2 && s_r.slow) begin
					s_nxt.bst = agu_pkg::AGU_T_3;
				end else begin
					s_nxt.data = shifted;
					if (3'({1'b0, s_r.beat}) + 3'h1 == s_r.nbeats) begin
						s_nxt.bst = agu_pkg::AGU_T_IDLE;
						s_nxt.bus.rd = 1'b0;
						s_nxt.bus.wr = 1'b0;
						s_nxt.done = 1'b1;
						if (s_r.mind)
							s_nxt.target = shifted[23:0];
						else
							s_nxt.result = shifted;
						if (s_r.postinc)
							s_nxt.rf[s_r.wb_idx] = s_r.wb_val;
					end else begin
						// Back-to-back cycles keep the split access indivisible
						s_nxt.bst = agu_pkg::AGU_T_1;
						s_nxt.beat = s_r.beat + 2'h1;
						s_nxt.bus.addr = s_r.bus.addr + (s_r.bb ? 16'h0001 : 16'h0002);
						s_nxt.wl = s_r.bb ? {s_r.wl[23:0], 8'h00} : {s_r.wl[15:0], 16'h0000};
						s_nxt.bus.wdata = s_r.bb ? {s_nxt.wl[31:24], s_nxt.wl[31:24]} :
							s_nxt.wl[31:16];
					end
				end
			end
		endcase
		s_nxt.ready = s_nxt.bst == agu_pkg::AGU_T_IDLE && s_nxt.cpu == agu_pkg::AGU_CPU_EXEC;
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus_out = s_r.bus;
	assign ready_out = s_r.ready;
	assign done_out = s_r.done;
	assign err_out = s_r.err;
	assign result_out = s_r.result;
	assign target_out = s_r.target;
	assign bitnum_out = s_r.bitnum;
	assign trap_sel_out = s_r.trap_sel;
	assign cpu_state_out = s_r.cpu;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic acc_bus;
	assign acc_bus = acc && legal && !no_bus && !bad_width;

	sequence s_fast_cycle;
		s_r.bst == agu_pkg::AGU_T_2 ##1 s_r.bst != agu_pkg::AGU_T_3;
	endsequence

	sequence s_slow_cycle;
		s_r.bst == agu_pkg::AGU_T_2 ##1 s_r.bst == agu_pkg::AGU_T_3;
	endsequence

	property p_abs8;
		@(posedge clk_in) disable iff (!rstn_in)
		acc_bus && req_in.mode == agu_pkg::AGU_M_ABS && req_in.ext_len == 2'h0 |=>
		bus_out.addr == {8'hFF, $past(req_in.ext[7:0])};
	endproperty
	a_abs8: assert property (p_abs8) else $error("short absolute not in top page");

	property p_abs16;
		@(posedge clk_in) disable iff (!rstn_in)
		acc_bus && req_in.mode == agu_pkg::AGU_M_ABS && req_in.ext_len == 2'h1 |=>
		bus_out.addr == $past(req_in.ext[15:0]);
	endproperty
	a_abs16: assert property (p_abs16) else $error("16-bit absolute address wrong");

	property p_mind;
		@(posedge clk_in) disable iff (!rstn_in)
		acc_bus && req_in.mode == agu_pkg::AGU_M_MIND |=>
		bus_out.addr[15:8] == 8'h00 && bus_out.rd;
	endproperty
	a_mind: assert property (p_mind) else $error("pointer address not zero-extended");

	property p_predec;
		@(posedge clk_in) disable iff (!rstn_in)
		acc_bus && req_in.mode == agu_pkg::AGU_M_PREDEC && !rf_we_in |=>
		s_r.rf[$past(req_in.reg_sel[2:0])] == $past(regv) - $past(step) &&
		bus_out.addr == s_r.rf[$past(req_in.reg_sel[2:0])][15:0];
	endproperty
	a_predec: assert property (p_predec) else $error("pre-decrement result wrong");

	property p_fast;
		@(posedge clk_in) disable iff (!rstn_in)
		s_r.bst == agu_pkg::AGU_T_1 && !s_r.slow |=> s_fast_cycle;
	endproperty
	a_fast: assert property (p_fast) else $error("two-state cycle stretched");

	property p_slow;
		@(posedge clk_in) disable iff (!rstn_in)
		s_r.bst == agu_pkg::AGU_T_1 && s_r.slow |=> s_slow_cycle;
	endproperty
	a_slow: assert property (p_slow) else $error("three-state cycle too short");

	property p_split;
		@(posedge clk_in) disable iff (!rstn_in)
		acc_bus && !wide && req_in.size == agu_pkg::AGU_SZ_WORD &&
		ea16 < PERIPH_SLOW_BASE |-> ##3 bus_out.byte_sz && s_r.bst == agu_pkg::AGU_T_1
		##2 done_out;
	endproperty
	a_split: assert property (p_split) else $error("narrow word access not split");

	property p_imm;
		@(posedge clk_in) disable iff (!rstn_in)
		acc && legal && req_in.mode == agu_pkg::AGU_M_IMM && req_in.size == agu_pkg::AGU_SZ_BYTE
		|=> done_out && !err_out && result_out == {24'h00_0000, $past(req_in.ext[7:0])};
	endproperty
	a_imm: assert property (p_imm) else $error("byte immediate wrong");

	property p_arith;
		@(posedge clk_in) disable iff (!rstn_in)
		acc && req_in.cls == agu_pkg::AGU_C_ARITH && req_in.mode != agu_pkg::AGU_M_REG &&
		req_in.mode != agu_pkg::AGU_M_IMM |=> done_out && err_out && !bus_out.rd && !bus_out.wr;
	endproperty
	a_arith: assert property (p_arith) else $error("arithmetic took memory operand");

endmodule

// File: tb/agu_mem_model.sv
// Purpose: On-chip memory and peripheral side of the block's bus
// Assumes: Read data is taken by the block in the last state of a beat
// Notes: Content is a fixed pattern of the address, so no storage is kept
`timescale 1ns/1ps

module agu_mem_model #(
	parameter logic [15:0] WIDE_BASE = 16'hF000,
	parameter logic [15:0] WIDE_END = 16'hF7FF
) (
	// Clock
	input wire logic clk_in,
	// Bus from the block
	input wire agu_pkg::agu_bus_t bus_in,
	// Answer
	output logic [15:0] rdata_out,
	output logic bad_out
);
	logic [15:0] last_r = 16'h0000;
	logic bad_r = 1'b0;

	function automatic logic [7:0] pt(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'hA5;
	endfunction

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Released lines toggle so a stale value never passes for data
	always_comb begin
		if (bus_in.rd) begin
			if (bus_in.byte_sz) begin
				rdata_out = {~pt(bus_in.addr), pt(bus_in.addr)};
			end else begin
				rdata_out = {pt(bus_in.addr), pt(bus_in.addr + 16'h0001)};
			end
		end else begin
			rdata_out = ~last_r;
		end
	end

	// ----------------------------------------
	// Access watch
	// ----------------------------------------
	always @(posedge clk_in) begin
		last_r <= rdata_out;
		if ((bus_in.rd || bus_in.wr) && bus_in.byte_sz && bus_in.addr >= WIDE_BASE
			&& bus_in.addr <= WIDE_END) begin
			bad_r <= 1'b1;
		end
	end
	assign bad_out = bad_r;
endmodule

// File: tb/agu_core_bench.sv
// Purpose: Self-checking bench of the address generation block
// Assumes: Inputs change at the falling edge; pattern memory as far side
// Notes: Reset checks and register loads first, then table rows, then state, bit, trap and write cases
`timescale 1ns/1ps

module agu_core_bench;
	localparam agu_pkg::agu_cls_t XF = agu_pkg::AGU_C_XFER;
	localparam agu_pkg::agu_cls_t AR = agu_pkg::AGU_C_ARITH;
	localparam agu_pkg::agu_cls_t BR = agu_pkg::AGU_C_BRANCH;
	localparam agu_pkg::agu_cls_t BT = agu_pkg::AGU_C_BIT;
	localparam agu_pkg::agu_mode_t RG = agu_pkg::AGU_M_REG;
	localparam agu_pkg::agu_mode_t IND = agu_pkg::AGU_M_IND;
	localparam agu_pkg::agu_mode_t DSP = agu_pkg::AGU_M_DISP;
	localparam agu_pkg::agu_mode_t PIN = agu_pkg::AGU_M_POSTINC;
	localparam agu_pkg::agu_mode_t PDE = agu_pkg::AGU_M_PREDEC;
	localparam agu_pkg::agu_mode_t ABS = agu_pkg::AGU_M_ABS;
	localparam agu_pkg::agu_mode_t IMM = agu_pkg::AGU_M_IMM;
	localparam agu_pkg::agu_mode_t PCR = agu_pkg::AGU_M_PCREL;
	localparam agu_pkg::agu_mode_t MND = agu_pkg::AGU_M_MIND;
	localparam agu_pkg::agu_size_t B = agu_pkg::AGU_SZ_BYTE;
	localparam agu_pkg::agu_size_t W = agu_pkg::AGU_SZ_WORD;
	localparam agu_pkg::agu_size_t L = agu_pkg::AGU_SZ_LONG;

	typedef struct packed {
		agu_pkg::agu_cls_t c;
		agu_pkg::agu_mode_t m;
		agu_pkg::agu_size_t s;
		logic [3:0] rs;
		logic [1:0] el;
		logic [31:0] x;
		logic [23:0] t;
		logic [31:0] r;
		logic [1:0] f;
		logic [3:0] cy;
	} agu_row_t;

	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic req_valid_in = 1'b0;
	agu_pkg::agu_req_t req_in = '0;
	logic rf_we_in = 1'b0;
	logic [2:0] rf_idx_in = 3'h0;
	logic [31:0] rf_data_in = 32'h0000_0000;
	logic sleep_in = 1'b0;
	logic wake_in = 1'b0;
	logic exc_in = 1'b0;
	logic exc_done_in = 1'b0;
	logic [15:0] bus_rdata_in;
	agu_pkg::agu_bus_t bus_out;
	logic ready_out;
	logic done_out;
	logic err_out;
	logic [31:0] result_out;
	logic [23:0] target_out;
	logic [2:0] bitnum_out;
	logic [1:0] trap_sel_out;
	agu_pkg::agu_cpu_t cpu_state_out;
	logic bad;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	agu_row_t rows[$];
	agu_pkg::agu_bus_t b;
	int n;
	logic e;
	logic d;

	agu_core u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
		.req_in(req_in), .rf_we_in(rf_we_in), .rf_idx_in(rf_idx_in), .rf_data_in(rf_data_in),
		.sleep_in(sleep_in), .wake_in(wake_in), .exc_in(exc_in), .exc_done_in(exc_done_in),
		.bus_rdata_in(bus_rdata_in), .bus_out(bus_out), .ready_out(ready_out),
		.done_out(done_out), .err_out(err_out), .result_out(result_out),
		.target_out(target_out), .bitnum_out(bitnum_out), .trap_sel_out(trap_sel_out),
		.cpu_state_out(cpu_state_out));
	agu_mem_model u_mem (.clk_in(clk_in), .bus_in(bus_out), .rdata_out(bus_rdata_in),
		.bad_out(bad));

	always #2 clk_in = ~clk_in;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] pt(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'hA5;
	endfunction
	function automatic logic [31:0] bt(input logic [15:0] a);
		return {24'h00_0000, pt(a)};
	endfunction
	function automatic logic [31:0] wd(input logic [15:0] a);
		return {16'h0000, pt(a), pt(a + 16'h0001)};
	endfunction
	function automatic logic [31:0] lg(input logic [15:0] a);
		return {wd(a), 16'h0000} | wd(a + 16'h0002);
	endfunction
	function automatic void add(agu_pkg::agu_cls_t c, agu_pkg::agu_mode_t m,
		agu_pkg::agu_size_t s, logic [3:0] rs, logic [1:0] el, logic [31:0] x,
		logic [23:0] t, logic [31:0] r, logic [1:0] f, logic [3:0] cy);
		rows.push_back('{c, m, s, rs, el, x, t, r, f, cy});
	endfunction

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic chk_st(input string nm, input agu_pkg::agu_cpu_t ex);
		n_tests++;
		if (cpu_state_out !== ex) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, ex, cpu_state_out);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Valid stays up so the next request can follow in the ready cycle
	task automatic go();
		int k;
		k = 0;
		req_valid_in = 1'b1;
		while (ready_out !== 1'b1 && k < 20) begin
			@(negedge clk_in);
			k++;
		end
		@(negedge clk_in);
		n = 1;
		b = bus_out;
		while (done_out !== 1'b1 && n < 40) begin
			@(negedge clk_in);
			n++;
		end
		e = err_out;
	endtask
	task automatic evt(input int k, input agu_pkg::agu_cpu_t s);
		int j;
		{exc_done_in, exc_in, wake_in, sleep_in} = 4'h1 << k;
		@(negedge clk_in);
		{exc_done_in, exc_in, wake_in, sleep_in} = 4'h0;
		j = 0;
		while (cpu_state_out !== s && j < 8) begin
			@(negedge clk_in);
			j++;
		end
		chk_st("cpu state", s);
	endtask

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(negedge clk_in);
		chk_st("cpu in reset", agu_pkg::AGU_CPU_RESET);
		chk("ready in reset", 32'h0000_0000, {31'h0, ready_out});
		rstn_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk_st("cpu after reset", agu_pkg::AGU_CPU_EXEC);
		rf_we_in = 1'b1;
		for (int i = 0; i < 6; i++) begin
			rf_idx_in = i[2:0];
			rf_data_in = i == 0 ? 32'h0012_3440 : i == 1 ? 32'h0000_0005 : i == 2 ? 32'h0000_2000
				: i == 3 ? 32'h0000_3000 : i == 4 ? 32'h0000_0000 : 32'hA1B2_C3D4;
			@(negedge clk_in);
		end
		rf_we_in = 1'b0;
		$display("test reset done");
		add(XF, IND, W, 4'h0, 2'h0, 32'h0, 24'h12_3440, wd(16'h3440), 2'h3, 4'h3);
		add(XF, DSP, W, 4'h0, 2'h1, 32'h0000_FFF0, 24'h12_3430, wd(16'h3430), 2'h3, 4'h3);
		add(XF, DSP, W, 4'h0, 2'h2, 32'h0001_0000, 24'h13_3440, wd(16'h3440), 2'h3, 4'h3);
		add(XF, ABS, B, 4'h0, 2'h0, 32'h0000_0080, 24'hFF_FF80, bt(16'hFF80), 2'h3, 4'h3);
		add(XF, ABS, W, 4'h0, 2'h1, 32'h0000_8000, 24'hFF_8000, wd(16'h8000), 2'h3, 4'h3);
		add(XF, ABS, W, 4'h0, 2'h2, 32'h0000_ABCE, 24'h00_ABCE, wd(16'hABCE), 2'h3, 4'h3);
		add(XF, ABS, W, 4'h0, 2'h1, 32'h0000_F100, 24'hFF_F100, wd(16'hF100), 2'h3, 4'h3);
		add(XF, ABS, W, 4'h0, 2'h1, 32'h0000_F800, 24'hFF_F800, wd(16'hF800), 2'h3, 4'h5);
		add(XF, ABS, W, 4'h0, 2'h1, 32'h0000_FC10, 24'hFF_FC10, wd(16'hFC10), 2'h3, 4'h7);
		add(XF, ABS, B, 4'h0, 2'h1, 32'h0000_FC11, 24'hFF_FC11, bt(16'hFC11), 2'h3, 4'h4);
		add(XF, ABS, B, 4'h0, 2'h1, 32'h0000_F100, 24'h0, 32'h0, 2'h0, 4'h0);
		add(XF, ABS, L, 4'h0, 2'h1, 32'h0000_1000, 24'h00_1000, lg(16'h1000), 2'h3, 4'h5);
		add(XF, ABS, L, 4'h0, 2'h1, 32'h0000_F802, 24'hFF_F802, lg(16'hF802), 2'h3, 4'h9);
		add(XF, PCR, W, 4'h0, 2'h0, 32'h0, 24'h0, 32'h0, 2'h0, 4'h0);
		add(XF, MND, W, 4'h0, 2'h0, 32'h0, 24'h0, 32'h0, 2'h0, 4'h0);
		add(AR, IND, W, 4'h0, 2'h0, 32'h0, 24'h0, 32'h0, 2'h0, 4'h0);
		add(BT, DSP, B, 4'h0, 2'h1, 32'h0, 24'h0, 32'h0, 2'h0, 4'h0);
		add(AR, RG, L, 4'h5, 2'h0, 32'h0, 24'h0, 32'hA1B2_C3D4, 2'h2, 4'h1);
		add(AR, RG, B, 4'h5, 2'h0, 32'h0, 24'h0, 32'h0000_00C3, 2'h2, 4'h1);
		add(AR, RG, B, 4'hD, 2'h0, 32'h0, 24'h0, 32'h0000_00D4, 2'h2, 4'h1);
		add(AR, RG, W, 4'hD, 2'h0, 32'h0, 24'h0, 32'h0000_A1B2, 2'h2, 4'h1);
		add(AR, IMM, L, 4'h0, 2'h3, 32'h89AB_CDEF, 24'h0, 32'h89AB_CDEF, 2'h2, 4'h1);
		add(BR, PCR, W, 4'h0, 2'h0, 32'h0000_0080, 24'h00_0F80, 32'h0, 2'h1, 4'h1);
		add(BR, PCR, W, 4'h0, 2'h1, 32'h0000_7FFE, 24'h00_8FFE, 32'h0, 2'h1, 4'h1);
		add(BR, MND, L, 4'h0, 2'h0, 32'h0000_00F0, {pt(16'h00F1), pt(16'h00F2),
			pt(16'h00F3)}, 32'h0, 2'h1, 4'h5);
		add(XF, PIN, W, 4'h2, 2'h0, 32'h0, 24'h00_2000, wd(16'h2000), 2'h3, 4'h3);
		add(AR, RG, L, 4'h2, 2'h0, 32'h0, 24'h0, 32'h0000_2002, 2'h2, 4'h1);
		add(XF, PDE, L, 4'h3, 2'h0, 32'h0, 24'h00_2FFC, lg(16'h2FFC), 2'h3, 4'h5);
		add(AR, RG, L, 4'h3, 2'h0, 32'h0, 24'h0, 32'h0000_2FFC, 2'h2, 4'h1);
		add(XF, PDE, B, 4'h4, 2'h0, 32'h0, 24'hFF_FFFF, bt(16'hFFFF), 2'h3, 4'h3);
		add(AR, RG, L, 4'h4, 2'h0, 32'h0, 24'h0, 32'hFFFF_FFFF, 2'h2, 4'h1);
		foreach (rows[i]) begin
			req_in = '0;
			{req_in.cls, req_in.mode, req_in.size} = {rows[i].c, rows[i].m, rows[i].s};
			{req_in.reg_sel, req_in.ext_len, req_in.ext} = {rows[i].rs, rows[i].el, rows[i].x};
			req_in.pc = 24'h00_1000;
			req_in.bitop = agu_pkg::AGU_B_TST;
			go();
			chk("cycles", rows[i].cy == 4'h0 ? 1 : rows[i].cy, n);
			chk("error", {31'h0, rows[i].cy == 4'h0}, {31'h0, e});
			if (rows[i].f[0]) chk("target", rows[i].t, target_out);
			if (rows[i].f[1]) chk("result", rows[i].r, result_out);
			if (rows[i].cy > 4'h1) begin
				chk("bus address", rows[i].m == MND ? 16'h00F0 : rows[i].t[15:0], b.addr);
			end
		end
		req_valid_in = 1'b0;
		$display("test table done");
		evt(0, agu_pkg::AGU_CPU_HALT);
		chk("ready halted", 32'h0, {31'h0, ready_out});
		req_in.mode = IMM;
		req_in.cls = AR;
		req_valid_in = 1'b1;
		d = 1'b0;
		repeat (4) begin
			@(negedge clk_in);
			d = d | done_out;
		end
		req_valid_in = 1'b0;
		chk("done while halted", 32'h0, {31'h0, d});
		evt(1, agu_pkg::AGU_CPU_EXEC);
		evt(2, agu_pkg::AGU_CPU_EXC);
		evt(3, agu_pkg::AGU_CPU_EXEC);
		$display("test states done");
		req_in = '0;
		{req_in.cls, req_in.mode, req_in.bit_from_reg, req_in.bit_reg} = {BT, IND, 1'b1, 3'h1};
		req_in.bitop = agu_pkg::AGU_B_SET;
		go();
		chk("bit number", 32'h5, {29'h0, bitnum_out});
		req_in.bitop = agu_pkg::AGU_B_OTHER;
		go();
		chk("bit other error", 32'h1, {31'h0, e});
		req_in = '0;
		{req_in.cls, req_in.mode, req_in.trap, req_in.ext_len, req_in.ext} = {AR, IMM, 1'b1,
			2'h0, 32'h0000_0002};
		go();
		chk("trap select", 32'h2, {30'h0, trap_sel_out});
		{req_in.cls, req_in.mode, req_in.size, req_in.write} = {XF, IND, W, 1'b1};
		req_in.wdata = 32'h0000_BEEF;
		go();
		chk("write word strobe", 32'h1, {31'h0, b.wr});
		chk("write word", 32'h3440_BEEF, {b.addr, b.wdata});
		{req_in.cls, req_in.mode, req_in.size, req_in.ext_len} = {XF, ABS, B, 2'h1};
		{req_in.ext, req_in.wdata} = {32'h0000_FC10, 32'h0000_005A};
		go();
		req_valid_in = 1'b0;
		chk("write byte", 32'h3_5A5A, {b.wr, b.byte_sz, b.wdata});
		chk("write byte cycles", 32'h4, n);
		chk("wide byte beat", 32'h0, {31'h0, bad});
		$display("test bit trap write done");
		conclude();
	end
endmodule
